//--- hdl/rmp_parser.sv
// Receive-side message parser: walks the submessages of one message and keeps receiver state.
// Assumes the transport gives msg_start_i with the total length, then that many bytes.
// Notes on behaviour
// - Flag field is eight bits, fixed byte-order position.
// - Byte order flag is flag bit zero.
// - Flag clear is big-endian, set little-endian.
// - Unknown and unused flag bits are ignored.
// - Length field is sixteen bits, skips ahead.
// - Length excludes the submessage header.
// - Nonzero length gives distance to next header.
// - Zero length means last, up to end.
// - State reset per message, kept across submessages.
// - Reset version, vendor, prefixes and timestamp.
// - Unicast reply list gets one transport locator.
// - Multicast reply list gets one invalid locator.
// - Short submessage header discards rest of message.
// - Length past message end discards the rest.
// - Unknown submessage kinds are skipped.
// - Vendor kinds from unknown vendor skipped.
// - Next submessage always found from length.
// - Invalid known submessage discards the rest; the code checks only info submessage lengths against their minimums.
// - Only header and info submessages change state.
// - Endpoint submessages are forwarded to the endpoint.
// - Kind codes keep extension and vendor ranges.
// - Every message starts with the protocol header.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
`include "rmp_regs.svh"

module rmp_parser #(
	parameter int LEN_W = 20,
	parameter logic [15:0] KNOWN_VENDOR = 16'h0000
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic msg_start_i,
	input wire logic [LEN_W-1:0] msg_len_i,
	input wire logic [31:0] xport_kind_i,
	input wire logic [127:0] src_addr_i,
	input wire logic src_addr_ok_i,
	input wire logic [95:0] local_prefix_i,
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_i,
	output logic sub_start_o,
	output rmp_pkg::rmp_sub_hdr_s sub_hdr_o,
	output logic sub_fwd_o,
	output logic fwd_valid_o,
	output logic [7:0] fwd_byte_o,
	output logic fwd_last_o,
	output logic msg_done_o,
	output logic msg_drop_o,
	output rmp_pkg::rmp_drop_e drop_cause_o,
	output logic [15:0] sender_protocol_version_o,
	output logic [15:0] sender_vendor_code_o,
	output logic [95:0] sender_prefix_o,
	output logic [95:0] target_prefix_o,
	output rmp_pkg::rmp_locator_s unicast_reply_list_o,
	output rmp_pkg::rmp_locator_s multicast_reply_list_o,
	output logic time_present_flag_o,
	output logic [63:0] timestamp_o
);
	import rmp_pkg::*;

	localparam logic [LEN_W-1:0] HDR_LAST = LEN_W'(`RMP_HDR_BYTES - 1);
	localparam logic [LEN_W-1:0] SUBHDR_LAST = LEN_W'(`RMP_SUBHDR_BYTES - 1);
	localparam logic [LEN_W-1:0] SUBHDR_SIZE = LEN_W'(`RMP_SUBHDR_BYTES);
	localparam logic [31:0] PROTO_ID = `RMP_PROTO_ID;

	logic rst_meta_q;
	logic rst_n_q;
	rmp_state_e st_q;
	logic [LEN_W-1:0] rem_q;
	logic [LEN_W-1:0] cnt_q;
	logic [LEN_W-1:0] body_rem_q;
	logic [LEN_W-1:0] body_q;
	logic [7:0] kind_q;
	logic [7:0] flags_q;
	logic [7:0] len_lo_q;
	rmp_action_e act_q;
	logic proto_bad_q;
	logic rep_cnt_q;
	logic [1:0] ctrl_q;
	logic [15:0] known_vendor_q;
	logic [15:0] drops_q;

	logic take;
	logic [LEN_W-1:0] rem_nx;
	logic [15:0] len_dec;
	logic [LEN_W-1:0] body_len;
	logic len_bad;
	rmp_action_e act_c;
	logic [LEN_W-1:0] min_c;
	logic inval;
	logic bnd_done;
	logic bnd_short;
	logic low_c;
	logic [4:0] off_c;
	logic le;

	// Shifts one byte into a 32-bit word in the byte order of the submessage.
	function automatic logic [31:0] shift_word(input logic [31:0] w, input logic [7:0] b, input logic little);
		return little ? {b, w[31:8]} : {w[23:0], b};
	endfunction : shift_word

	// Reset release through two flip-flops.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// Decisions taken on the byte being consumed.
	always_comb
	begin
		take = byte_valid_i && !msg_start_i && (st_q != RMP_ST_IDLE);
		rem_nx = rem_q - LEN_W'(1);
		le = flags_q[`RMP_FLAG_BYTE_ORDER];
		len_dec = le ? {byte_i, len_lo_q} : {len_lo_q, byte_i};
		body_len = (len_dec == 16'h0000) ? rem_nx : LEN_W'(len_dec);
		len_bad = (len_dec != 16'h0000) && (LEN_W'(len_dec) > rem_nx);
		low_c = cnt_q < LEN_W'(32);
		off_c = cnt_q[4:0];
		bnd_done = rem_nx == '0;
		bnd_short = !bnd_done && (rem_nx < SUBHDR_SIZE);
		min_c = '0;
		act_c = RMP_ACT_SKIP;
		if (kind_q >= `RMP_KIND_VENDOR_LO)
		begin
			act_c = (sender_vendor_code_o == known_vendor_q) ? RMP_ACT_FWD : RMP_ACT_SKIP;
		end
		else
		begin
			unique case (kind_q)
				`RMP_KIND_ACKNACK, `RMP_KIND_HEARTBEAT, `RMP_KIND_GAP, `RMP_KIND_NACK_FRAG,
				`RMP_KIND_HB_FRAG, `RMP_KIND_DATA, `RMP_KIND_DATA_FRAG: act_c = RMP_ACT_FWD;
				`RMP_KIND_INFO_SRC:
				begin
					act_c = RMP_ACT_SRC;
					min_c = LEN_W'(`RMP_MIN_SRC);
				end
				`RMP_KIND_INFO_DST:
				begin
					act_c = RMP_ACT_DST;
					min_c = LEN_W'(`RMP_MIN_DST);
				end
				`RMP_KIND_INFO_TS:
				begin
					act_c = RMP_ACT_TS;
					min_c = flags_q[`RMP_FLAG_TS_INVALIDATE] ? '0 : LEN_W'(`RMP_MIN_TS);
				end
				`RMP_KIND_INFO_REPLY:
				begin
					act_c = RMP_ACT_REPLY;
					min_c = LEN_W'(`RMP_MIN_REPLY);
				end
				default: act_c = RMP_ACT_SKIP;
			endcase
		end
		inval = body_len < min_c;
	end

	// Parser state machine, byte counters and submessage header capture.
	always_ff @(posedge ref_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			st_q <= RMP_ST_IDLE;
			rem_q <= '0;
			cnt_q <= '0;
			body_rem_q <= '0;
			body_q <= '0;
			kind_q <= 8'h00;
			flags_q <= 8'h00;
			len_lo_q <= 8'h00;
			act_q <= RMP_ACT_SKIP;
			proto_bad_q <= 1'b0;
		end
		else if (msg_start_i && ctrl_q[`RMP_CTRL_EN_BIT])
		begin
			rem_q <= msg_len_i;
			cnt_q <= '0;
			proto_bad_q <= 1'b0;
			st_q <= (msg_len_i < LEN_W'(`RMP_HDR_BYTES)) ? RMP_ST_DROP : RMP_ST_HDR;
		end
		else if (st_q == RMP_ST_DROP && rem_q == '0)
		begin
			st_q <= RMP_ST_IDLE;
		end
		else if (take)
		begin
			rem_q <= rem_nx;
			cnt_q <= cnt_q + LEN_W'(1);
			unique case (st_q)
				RMP_ST_HDR:
				begin
					if (cnt_q < LEN_W'(4) && byte_i != PROTO_ID[8'(31 - 8 * cnt_q[1:0]) -: 8])
					begin
						proto_bad_q <= ctrl_q[`RMP_CTRL_CHK_BIT];
					end
					if (cnt_q == HDR_LAST)
					begin
						cnt_q <= '0;
						st_q <= (proto_bad_q || bnd_short) ? RMP_ST_DROP : (bnd_done ? RMP_ST_IDLE : RMP_ST_SUBHDR);
					end
				end
				RMP_ST_SUBHDR:
				begin
					if (cnt_q == '0)
						kind_q <= byte_i;
					if (cnt_q == LEN_W'(1))
						flags_q <= byte_i;
					if (cnt_q == LEN_W'(2))
						len_lo_q <= byte_i;
					if (cnt_q == SUBHDR_LAST)
					begin
						cnt_q <= '0;
						act_q <= act_c;
						body_q <= body_len;
						body_rem_q <= body_len;
						if (len_bad || inval || (body_len == '0 && bnd_short))
							st_q <= RMP_ST_DROP;
						else if (body_len == '0)
							st_q <= bnd_done ? RMP_ST_IDLE : RMP_ST_SUBHDR;
						else
							st_q <= RMP_ST_BODY;
					end
				end
				RMP_ST_BODY:
				begin
					body_rem_q <= body_rem_q - LEN_W'(1);
					if (body_rem_q == LEN_W'(1))
					begin
						cnt_q <= '0;
						st_q <= bnd_short ? RMP_ST_DROP : (bnd_done ? RMP_ST_IDLE : RMP_ST_SUBHDR);
					end
				end
				RMP_ST_DROP:
				begin
					if (bnd_done)
						st_q <= RMP_ST_IDLE;
				end
				RMP_ST_IDLE:
				begin
					cnt_q <= '0;
				end
			endcase
		end
	end

	// Receiver state: set up per message, changed by header and info submessages.
	always_ff @(posedge ref_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			sender_protocol_version_o <= `RMP_VERSION_CURRENT;
			sender_vendor_code_o <= `RMP_VENDOR_UNKNOWN;
			sender_prefix_o <= `RMP_PREFIX_UNKNOWN;
			target_prefix_o <= `RMP_PREFIX_UNKNOWN;
			unicast_reply_list_o <= '{kind: 32'h0, port: `RMP_PORT_INVALID, addr: `RMP_ADDR_INVALID};
			multicast_reply_list_o <= '{kind: 32'h0, port: `RMP_PORT_INVALID, addr: `RMP_ADDR_INVALID};
			time_present_flag_o <= 1'b0;
			timestamp_o <= `RMP_TIME_INVALID;
			rep_cnt_q <= 1'b0;
		end
		else if (msg_start_i && ctrl_q[`RMP_CTRL_EN_BIT])
		begin
			sender_protocol_version_o <= `RMP_VERSION_CURRENT;
			sender_vendor_code_o <= `RMP_VENDOR_UNKNOWN;
			sender_prefix_o <= `RMP_PREFIX_UNKNOWN;
			target_prefix_o <= local_prefix_i;
			time_present_flag_o <= 1'b0;
			timestamp_o <= `RMP_TIME_INVALID;
			unicast_reply_list_o.kind <= xport_kind_i;
			unicast_reply_list_o.addr <= src_addr_ok_i ? src_addr_i : `RMP_ADDR_INVALID;
			unicast_reply_list_o.port <= `RMP_PORT_INVALID;
			multicast_reply_list_o <= '{kind: xport_kind_i, port: `RMP_PORT_INVALID, addr: `RMP_ADDR_INVALID};
		end
		else if (take && st_q == RMP_ST_HDR && low_c)
		begin
			if (off_c == 5'd4 || off_c == 5'd5)
				sender_protocol_version_o <= {sender_protocol_version_o[7:0], byte_i};
			if (off_c == 5'd6 || off_c == 5'd7)
				sender_vendor_code_o <= {sender_vendor_code_o[7:0], byte_i};
			if (off_c >= 5'd8)
				sender_prefix_o <= {sender_prefix_o[87:0], byte_i};
		end
		else if (take && st_q == RMP_ST_SUBHDR && cnt_q == SUBHDR_LAST)
		begin
			rep_cnt_q <= 1'b0;
			// only the invalidate flag is used
			if (act_c == RMP_ACT_TS && flags_q[`RMP_FLAG_TS_INVALIDATE] && !len_bad)
			begin
				time_present_flag_o <= 1'b0;
				timestamp_o <= `RMP_TIME_INVALID;
			end
		end
		else if (take && st_q == RMP_ST_BODY && low_c)
		begin
			unique case (act_q)
				RMP_ACT_SRC:
				begin
					if (off_c == 5'd4 || off_c == 5'd5)
						sender_protocol_version_o <= {sender_protocol_version_o[7:0], byte_i};
					if (off_c == 5'd6 || off_c == 5'd7)
						sender_vendor_code_o <= {sender_vendor_code_o[7:0], byte_i};
					if (off_c >= 5'd8 && off_c < 5'd20)
						sender_prefix_o <= {sender_prefix_o[87:0], byte_i};
				end
				RMP_ACT_DST:
				begin
					if (off_c < 5'd12)
						target_prefix_o <= {target_prefix_o[87:0], byte_i};
				end
				RMP_ACT_TS:
				begin
					if (!flags_q[`RMP_FLAG_TS_INVALIDATE] && off_c < 5'd4)
						timestamp_o[63:32] <= shift_word(timestamp_o[63:32], byte_i, le);
					if (!flags_q[`RMP_FLAG_TS_INVALIDATE] && off_c >= 5'd4 && off_c < 5'd8)
						timestamp_o[31:0] <= shift_word(timestamp_o[31:0], byte_i, le);
					if (!flags_q[`RMP_FLAG_TS_INVALIDATE] && off_c == 5'd7)
						time_present_flag_o <= 1'b1;
				end
				RMP_ACT_REPLY:
				begin
					if (off_c < 5'd4 && byte_i != 8'h00)
						rep_cnt_q <= 1'b1;
					if (rep_cnt_q && body_q >= LEN_W'(`RMP_MIN_REPLY_LOC))
					begin
						if (off_c >= 5'd4 && off_c < 5'd8)
							unicast_reply_list_o.kind <= shift_word(unicast_reply_list_o.kind, byte_i, le);
						if (off_c >= 5'd8 && off_c < 5'd12)
							unicast_reply_list_o.port <= shift_word(unicast_reply_list_o.port, byte_i, le);
						if (off_c >= 5'd12 && off_c < 5'd28)
							unicast_reply_list_o.addr <= {unicast_reply_list_o.addr[119:0], byte_i};
					end
				end
				default:
				begin
				end
			endcase
		end
	end

	// Event pulses and forwarded content bytes.
	always_ff @(posedge ref_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			sub_start_o <= 1'b0;
			sub_hdr_o <= '0;
			sub_fwd_o <= 1'b0;
			fwd_valid_o <= 1'b0;
			fwd_byte_o <= 8'h00;
			fwd_last_o <= 1'b0;
			msg_done_o <= 1'b0;
			msg_drop_o <= 1'b0;
			drop_cause_o <= RMP_DROP_NONE;
		end
		else
		begin
			sub_start_o <= 1'b0;
			fwd_valid_o <= 1'b0;
			fwd_last_o <= 1'b0;
			msg_done_o <= 1'b0;
			msg_drop_o <= 1'b0;
			if (msg_start_i && ctrl_q[`RMP_CTRL_EN_BIT])
			begin
				if (msg_len_i < LEN_W'(`RMP_HDR_BYTES))
				begin
					msg_drop_o <= 1'b1;
					drop_cause_o <= RMP_DROP_HDR_SHORT;
				end
			end
			else if (take && st_q == RMP_ST_HDR && cnt_q == HDR_LAST)
			begin
				msg_drop_o <= proto_bad_q || bnd_short;
				drop_cause_o <= proto_bad_q ? RMP_DROP_PROTO : (bnd_short ? RMP_DROP_SUBHDR_SHORT : drop_cause_o);
				msg_done_o <= !proto_bad_q && bnd_done;
			end
			else if (take && st_q == RMP_ST_SUBHDR && cnt_q == SUBHDR_LAST)
			begin
				if (len_bad || inval)
				begin
					msg_drop_o <= 1'b1;
					drop_cause_o <= len_bad ? RMP_DROP_LENGTH : RMP_DROP_INVALID;
				end
				else
				begin
					sub_start_o <= 1'b1;
					sub_hdr_o <= '{kind: kind_q, flags: flags_q, length: len_dec};
					sub_fwd_o <= act_c == RMP_ACT_FWD;
					if (body_len == '0)
					begin
						msg_drop_o <= bnd_short;
						drop_cause_o <= bnd_short ? RMP_DROP_SUBHDR_SHORT : drop_cause_o;
						msg_done_o <= bnd_done;
					end
				end
			end
			else if (take && st_q == RMP_ST_BODY)
			begin
				fwd_valid_o <= act_q == RMP_ACT_FWD;
				fwd_byte_o <= byte_i;
				fwd_last_o <= (act_q == RMP_ACT_FWD) && (body_rem_q == LEN_W'(1));
				if (body_rem_q == LEN_W'(1))
				begin
					msg_drop_o <= bnd_short;
					drop_cause_o <= bnd_short ? RMP_DROP_SUBHDR_SHORT : drop_cause_o;
					msg_done_o <= bnd_done;
				end
			end
		end
	end

	// Register port: control, known vendor, status and drop count.
	always_ff @(posedge ref_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ctrl_q <= `RMP_CTRL_RST;
			known_vendor_q <= KNOWN_VENDOR;
			drops_q <= 16'h0000;
			reg_rdata_o <= 32'h0;
		end
		else
		begin
			if (msg_drop_o)
				drops_q <= drops_q + 16'h0001;
			if (reg_wr_i && reg_addr_i == `RMP_CTRL_OFS)
				ctrl_q <= reg_wdata_i[1:0];
			if (reg_wr_i && reg_addr_i == `RMP_VENDOR_OFS)
				known_vendor_q <= reg_wdata_i[15:0];
			reg_rdata_o <= 32'h0;
			if (reg_rd_i)
			begin
				unique case (reg_addr_i)
					`RMP_CTRL_OFS: reg_rdata_o <= {30'h0, ctrl_q};
					`RMP_VENDOR_OFS: reg_rdata_o <= {16'h0, known_vendor_q};
					`RMP_STATUS_OFS: reg_rdata_o <= {23'h0, drop_cause_o, time_present_flag_o, st_q};
					`RMP_DROPS_OFS: reg_rdata_o <= {16'h0, drops_q};
					default: reg_rdata_o <= 32'h0;
				endcase
			end
		end
	end

endmodule : rmp_parser

//--- hdl/rmp_pkg.sv
// Types shared by the message parser and its users.
// Assumes the constants header is on the include path.
package rmp_pkg;

	// Parser states, one-hot.
	typedef enum logic [4:0] {
		RMP_ST_IDLE = 5'b00001,
		RMP_ST_HDR = 5'b00010,
		RMP_ST_SUBHDR = 5'b00100,
		RMP_ST_BODY = 5'b01000,
		RMP_ST_DROP = 5'b10000
	} rmp_state_e;

	// What the body of the current submessage is used for.
	typedef enum logic [2:0] {
		RMP_ACT_SKIP = 3'h0,
		RMP_ACT_FWD = 3'h1,
		RMP_ACT_SRC = 3'h2,
		RMP_ACT_DST = 3'h3,
		RMP_ACT_TS = 3'h4,
		RMP_ACT_REPLY = 3'h5
	} rmp_action_e;

	// Reason the rest of a message was thrown away.
	typedef enum logic [2:0] {
		RMP_DROP_NONE = 3'h0,
		RMP_DROP_HDR_SHORT = 3'h1,
		RMP_DROP_PROTO = 3'h2,
		RMP_DROP_SUBHDR_SHORT = 3'h3,
		RMP_DROP_LENGTH = 3'h4,
		RMP_DROP_INVALID = 3'h5
	} rmp_drop_e;

	// Decoded submessage header.
	typedef struct packed {
		logic [7:0] kind;
		logic [7:0] flags;
		logic [15:0] length;
	} rmp_sub_hdr_s;

	// One reply locator.
	typedef struct packed {
		logic [31:0] kind;
		logic [31:0] port;
		logic [127:0] addr;
	} rmp_locator_s;

endpackage : rmp_pkg

//--- hdl/rmp_regs.svh
// Constants of the message parser: register offsets, field positions, reset values, byte counts.
// Assumes it is included by its bare name from the parser module.
`ifndef RMP_REGS_SVH
`define RMP_REGS_SVH

// Register byte offsets on the plain register port.
`define RMP_CTRL_OFS 4'h0
`define RMP_VENDOR_OFS 4'h4
`define RMP_STATUS_OFS 4'h8
`define RMP_DROPS_OFS 4'hc

// Control register fields and reset value.
`define RMP_CTRL_EN_BIT 0
`define RMP_CTRL_CHK_BIT 1
`define RMP_CTRL_RST 2'h3

// Submessage flag positions.
`define RMP_FLAG_BYTE_ORDER 0
`define RMP_FLAG_TS_INVALIDATE 1

// Header and submessage header sizes in bytes.
`define RMP_HDR_BYTES 20
`define RMP_SUBHDR_BYTES 4

// Fixed protocol identifier carried in the first four header bytes.
`define RMP_PROTO_ID 32'h52545053

// Reset values of the receiver state.
`define RMP_VERSION_CURRENT 16'h0201
`define RMP_VENDOR_UNKNOWN 16'h0000
`define RMP_PREFIX_UNKNOWN 96'h0
`define RMP_TIME_INVALID 64'hffff_ffff_ffff_ffff
`define RMP_ADDR_INVALID 128'h0
`define RMP_PORT_INVALID 32'h0

// Submessage kind codes.
`define RMP_KIND_PAD 8'h01
`define RMP_KIND_ACKNACK 8'h06
`define RMP_KIND_HEARTBEAT 8'h07
`define RMP_KIND_GAP 8'h08
`define RMP_KIND_INFO_TS 8'h09
`define RMP_KIND_INFO_SRC 8'h0c
`define RMP_KIND_INFO_DST 8'h0e
`define RMP_KIND_INFO_REPLY 8'h0f
`define RMP_KIND_NACK_FRAG 8'h12
`define RMP_KIND_HB_FRAG 8'h13
`define RMP_KIND_DATA 8'h15
`define RMP_KIND_DATA_FRAG 8'h16
`define RMP_KIND_VENDOR_LO 8'h80

// Least content lengths of the state-changing submessages.
`define RMP_MIN_SRC 20
`define RMP_MIN_DST 12
`define RMP_MIN_TS 8
`define RMP_MIN_REPLY 4
`define RMP_MIN_REPLY_LOC 28

`endif

//--- tb/rmp_parser_sva.sv
// Port checker for the message parser.
// Assumes it is bound to rmp_parser and mirrors the enable and vendor registers itself.
`timescale 1ns/1ns
module rmp_parser_sva
	import rmp_pkg::*;
#(
	parameter int LEN_W = 20
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic msg_start_i,
	input wire logic [LEN_W-1:0] msg_len_i,
	input wire logic [31:0] xport_kind_i,
	input wire logic [127:0] src_addr_i,
	input wire logic src_addr_ok_i,
	input wire logic [95:0] local_prefix_i,
	input wire logic sub_start_o,
	input wire rmp_pkg::rmp_sub_hdr_s sub_hdr_o,
	input wire logic sub_fwd_o,
	input wire logic fwd_valid_o,
	input wire logic msg_drop_o,
	input wire rmp_pkg::rmp_drop_e drop_cause_o,
	input wire logic [15:0] sender_protocol_version_o,
	input wire logic [15:0] sender_vendor_code_o,
	input wire logic [95:0] sender_prefix_o,
	input wire logic [95:0] target_prefix_o,
	input wire rmp_pkg::rmp_locator_s unicast_reply_list_o,
	input wire rmp_pkg::rmp_locator_s multicast_reply_list_o,
	input wire logic time_present_flag_o,
	input wire logic [63:0] timestamp_o
);
	logic en_q;
	logic [15:0] vend_q;
	logic go;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	// Mirrors the enable bit so that ignored messages raise no checks.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
		if (!arst_n_i)
			en_q <= 1'h1;
		else if (reg_wr_i && reg_addr_i == 4'h0)
			en_q <= reg_wdata_i[0];

	// Mirrors the known vendor register.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
		if (!arst_n_i)
			vend_q <= 16'h0;
		else if (reg_wr_i && reg_addr_i == 4'h4)
			vend_q <= reg_wdata_i[15:0];

	// A message start that the parser accepts.
	assign go = msg_start_i && en_q;

	chk_state_init:
		assert property (go |=> sender_protocol_version_o == 16'h0201 && sender_vendor_code_o == 16'h0
			&& sender_prefix_o == 96'h0 && target_prefix_o == $past(local_prefix_i) && !time_present_flag_o
			&& timestamp_o == 64'hffffffffffffffff) else $error("receiver state not set up at message start");
	chk_unicast_init:
		assert property (go |=> unicast_reply_list_o == {$past(xport_kind_i), 32'h0,
			($past(src_addr_ok_i) ? $past(src_addr_i) : 128'h0)}) else $error("unicast reply locator wrong");
	chk_multicast_init:
		assert property (go |=> multicast_reply_list_o == {$past(xport_kind_i), 32'h0, 128'h0})
			else $error("multicast reply locator wrong");
	chk_short_header:
		assert property (go && msg_len_i < 20 |=> msg_drop_o && drop_cause_o == RMP_DROP_HDR_SHORT)
			else $error("short message not dropped");
	chk_drop_quiet:
		assert property (msg_drop_o |=> (!sub_start_o && !fwd_valid_o) [*8])
			else $error("activity after a discard");
	chk_vendor_skip:
		assert property (sub_start_o && sub_hdr_o.kind >= 8'h80 && sender_vendor_code_o != vend_q |-> !sub_fwd_o)
			else $error("vendor submessage of unknown vendor forwarded");
	chk_endpoint_fwd:
		assert property (sub_start_o && sub_hdr_o.kind inside {8'h06, 8'h07, 8'h08, 8'h12, 8'h13, 8'h15, 8'h16}
			|-> sub_fwd_o) else $error("endpoint submessage not forwarded");
	chk_other_skip:
		assert property (sub_start_o && sub_hdr_o.kind < 8'h80
			&& !(sub_hdr_o.kind inside {8'h06, 8'h07, 8'h08, 8'h12, 8'h13, 8'h15, 8'h16}) |-> !sub_fwd_o)
			else $error("non-endpoint submessage forwarded");
endmodule : rmp_parser_sva

bind rmp_parser rmp_parser_sva #(.LEN_W(LEN_W)) rmp_parser_sva_inst (.*);

//--- tb/rmp_xport_model.sv
// Transport model: hands whole messages to the parser, byte by byte.
// Assumes send is called right after a rising clock edge.
`timescale 1ns/1ns
module rmp_xport_model (
	input wire logic ref_clk_i,
	output logic msg_start_o,
	output logic [19:0] msg_len_o,
	output logic [31:0] xport_kind_o,
	output logic [127:0] src_addr_o,
	output logic src_addr_ok_o,
	output logic [95:0] local_prefix_o,
	output logic byte_valid_o,
	output logic [7:0] byte_o
);
	// Fixed transport kind and local prefix; lines idle at start.
	initial
	begin
		msg_start_o = 1'h0;
		msg_len_o = 20'h0;
		xport_kind_o = 32'h1;
		src_addr_o = 128'h0;
		src_addr_ok_o = 1'h0;
		local_prefix_o = 96'hc0c1c2c3c4c5c6c7c8c9cacb;
		byte_valid_o = 1'h0;
		byte_o = 8'h0;
	end

	task automatic send(input logic [7:0] q[$], input logic slow, input logic [127:0] src, input logic ok);
		msg_start_o <= 1'h1;
		msg_len_o <= 20'(q.size());
		src_addr_o <= src;
		src_addr_ok_o <= ok;
		@(posedge ref_clk_i);
		msg_start_o <= 1'h0;
		foreach (q[i])
		begin
			byte_valid_o <= 1'h1;
			byte_o <= q[i];
			@(posedge ref_clk_i);
			// A slow sender leaves gaps with the data line toggled, not held.
			if (slow)
			begin
				byte_valid_o <= 1'h0;
				byte_o <= ~q[i];
				@(posedge ref_clk_i);
			end
		end
		byte_valid_o <= 1'h0;
		byte_o <= ~byte_o;
	endtask : send
endmodule : rmp_xport_model

//--- tb/tb_top.sv
// Bench for the message parser: builds messages, sends them through the transport model, judges outputs.
// Assumes the package, the parser, the checker and the transport model are compiled first.
`timescale 1ns/1ns
module tb_top;
	import rmp_pkg::*;
	logic ref_clk_i, arst_n_i, reg_wr_i, reg_rd_i, msg_start_i, src_addr_ok_i, byte_valid_i;
	logic [3:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, xport_kind_i;
	logic [19:0] msg_len_i;
	logic [127:0] src_addr_i;
	logic [95:0] local_prefix_i, sender_prefix_o, target_prefix_o;
	logic [7:0] byte_i, fwd_byte_o, last_fwd;
	logic sub_start_o, sub_fwd_o, fwd_valid_o, fwd_last_o, msg_done_o, msg_drop_o, time_present_flag_o;
	rmp_sub_hdr_s sub_hdr_o, last_hdr;
	rmp_drop_e drop_cause_o;
	logic [15:0] sender_protocol_version_o, sender_vendor_code_o;
	rmp_locator_s unicast_reply_list_o, multicast_reply_list_o;
	logic [63:0] timestamp_o;
	logic [7:0] mq[$];
	int n_sub, n_fwd, n_done, n_drop, fails, checks;

	rmp_parser rmp_parser_inst (.*);
	rmp_xport_model rmp_xport_model_inst (.ref_clk_i(ref_clk_i), .msg_start_o(msg_start_i), .msg_len_o(msg_len_i),
		.xport_kind_o(xport_kind_i), .src_addr_o(src_addr_i), .src_addr_ok_o(src_addr_ok_i),
		.local_prefix_o(local_prefix_i), .byte_valid_o(byte_valid_i), .byte_o(byte_i));

	// Clock at 100 MHz.
	initial
	begin
		ref_clk_i = 1'h0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// Counts the parser's pulses and keeps the last accepted submessage header.
	always @(posedge ref_clk_i)
	begin
		n_sub += int'(sub_start_o === 1'h1);
		n_fwd += int'(fwd_valid_o === 1'h1);
		n_done += int'(msg_done_o === 1'h1);
		n_drop += int'(msg_drop_o === 1'h1);
		if (sub_start_o === 1'h1)
			last_hdr = sub_hdr_o;
		if (fwd_last_o === 1'h1)
			last_fwd = fwd_byte_o;
	end

	task automatic complete_run;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	task automatic check_val(input logic [127:0] got, input logic [127:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val

	// Register write and checked read, one strobe cycle each.
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'h1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'h0;
	endtask : reg_write

	task automatic reg_expect(input logic [3:0] a, input logic [31:0] exp);
		reg_addr_i <= a;
		reg_rd_i <= 1'h1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'h0;
		@(posedge ref_clk_i);
		check_val(128'(reg_rdata_o), 128'(exp));
	endtask : reg_expect

	task automatic put_hdr(input logic [15:0] vend);
		mq = {8'h52, 8'h54, 8'h50, 8'h53, 8'h02, 8'h01, vend[15:8], vend[7:0]};
		for (int i = 0; i < 12; i++)
			mq.push_back(8'(8'ha0 + i));
	endtask : put_hdr

	task automatic put_sub(input logic [7:0] kind, input logic [7:0] flags, input logic [15:0] len, input int n);
		mq.push_back(kind);
		mq.push_back(flags);
		mq.push_back(flags[0] ? len[7:0] : len[15:8]);
		mq.push_back(flags[0] ? len[15:8] : len[7:0]);
		for (int i = 0; i < n; i++)
			mq.push_back(8'(i + 1));
	endtask : put_sub

	// Sends the built message and waits, bounded, for its end or discard.
	task automatic run_msg(input logic slow, input logic ok);
		n_sub = 0;
		n_fwd = 0;
		n_done = 0;
		n_drop = 0;
		rmp_xport_model_inst.send(mq, slow, 128'h0a000001, ok);
		for (int i = 0; i < 20 && n_done + n_drop == 0; i++)
			@(negedge ref_clk_i);
		if (n_done + n_drop == 0)
		begin
			fails++;
			complete_run();
		end
		@(posedge ref_clk_i);
	endtask : run_msg

	// Judges counts; a negative submessage count is not judged.
	task automatic expect_end(input int sub, input int fwd, input int done, input logic [2:0] cause);
		if (sub >= 0)
			check_val(128'(n_sub), 128'(sub));
		check_val(128'(n_fwd), 128'(fwd));
		check_val(128'(n_done), 128'(done));
		check_val(128'(n_drop), 128'(1 - done));
		if (done == 0)
			check_val(128'(drop_cause_o), 128'(cause));
	endtask : expect_end

	task automatic sc_reset;
		check_val(128'({sender_protocol_version_o, sender_vendor_code_o, time_present_flag_o}), 128'h4020000);
		check_val(128'(timestamp_o), 128'hffffffffffffffff);
		reg_expect(4'h0, 32'h3);
		reg_expect(4'h2, 32'h0);
		reg_expect(4'h8, 32'h1);
		reg_expect(4'hc, 32'h0);
	endtask : sc_reset

	task automatic sc_basic;
		put_hdr(16'h1234);
		put_sub(8'h15, 8'h00, 16'h2, 2);
		run_msg(1'h0, 1'h1);
		expect_end(1, 2, 1, 3'h0);
		check_val(128'(last_hdr), 128'h15000002);
		check_val(128'({sender_vendor_code_o, sender_prefix_o}), 128'h1234a0a1a2a3a4a5a6a7a8a9aaab);
	endtask : sc_basic

	// mixed orders, unknown kind, final zero length
	task automatic sc_walk;
		put_hdr(16'h1234);
		put_sub(8'h15, 8'h01, 16'h2, 2);
		put_sub(8'h02, 8'h00, 16'h3, 3);
		put_sub(8'h07, 8'h01, 16'h0, 4);
		run_msg(1'h1, 1'h1);
		expect_end(3, 6, 1, 3'h0);
		check_val(128'(last_hdr), 128'h07010000);
		check_val(128'(last_fwd), 128'h4);
	endtask : sc_walk

	// vendor kind before and after the vendor is known
	task automatic sc_vendor;
		put_hdr(16'h1234);
		put_sub(8'h80, 8'h00, 16'h0, 2);
		run_msg(1'h0, 1'h0);
		expect_end(1, 0, 1, 3'h0);
		check_val(128'(unicast_reply_list_o.addr), 128'h0);
		reg_write(4'h4, 32'h1234);
		reg_expect(4'h4, 32'h1234);
		run_msg(1'h0, 1'h1);
		expect_end(1, 2, 1, 3'h0);
	endtask : sc_vendor

	task automatic sc_drops;
		put_hdr(16'h1);
		mq = mq[0:9];
		run_msg(1'h0, 1'h1);
		expect_end(0, 0, 0, 3'h1);
		put_hdr(16'h1);
		put_sub(8'h15, 8'h00, 16'h9, 2);
		run_msg(1'h0, 1'h1);
		expect_end(0, 0, 0, 3'h4);
		put_hdr(16'h1);
		put_sub(8'h15, 8'h00, 16'h2, 2);
		mq.push_back(8'h15);
		mq.push_back(8'h00);
		run_msg(1'h0, 1'h1);
		expect_end(1, 2, 0, 3'h3);
		put_hdr(16'h1);
		put_sub(8'h09, 8'h00, 16'h4, 4);
		put_sub(8'h15, 8'h00, 16'h0, 2);
		run_msg(1'h0, 1'h1);
		expect_end(0, 0, 0, 3'h5);
		put_hdr(16'h1);
		mq[0] = 8'h00;
		run_msg(1'h0, 1'h1);
		expect_end(0, 0, 0, 3'h2);
		reg_expect(4'hc, 32'h5);
	endtask : sc_drops

	// timestamp set, then cleared by the next message
	task automatic sc_time;
		put_hdr(16'h1);
		put_sub(8'h09, 8'h01, 16'h8, 8);
		put_sub(8'h15, 8'h00, 16'h0, 0);
		run_msg(1'h0, 1'h1);
		expect_end(2, 0, 1, 3'h0);
		check_val(128'({time_present_flag_o, timestamp_o}), {64'h1, 64'h0403020108070605});
		put_hdr(16'h1);
		run_msg(1'h0, 1'h1);
		check_val(128'({time_present_flag_o, timestamp_o}), 128'hffffffffffffffff);
	endtask : sc_time

	// Reset, then every scenario in turn.
	initial
	begin
		arst_n_i = 1'h0;
		reg_addr_i = 4'h0;
		reg_wdata_i = 32'h0;
		reg_wr_i = 1'h0;
		reg_rd_i = 1'h0;
		repeat (12) @(posedge ref_clk_i);
		arst_n_i <= 1'h1;
		repeat (3) @(posedge ref_clk_i);
		sc_reset();
		sc_basic();
		sc_walk();
		sc_vendor();
		sc_drops();
		sc_time();
		complete_run();
	end
endmodule : tb_top
